// ### fcr_regs.sv
// settings checksum, fault injection and ident word command registers
`timescale 1ns/10ps
// Behaviour
// - checksum is CRC-16, polynomial 0x8005
// - checksum is read-only 16-bit field
// - checksum recomputed at boot, store, restore
// - injection register read and written as word
// - injection forces matching detector output
// - several injections act together
// - fault hold bit: clear after response, else keep
// - warning hold bit: clear after response, else keep
// - fault bits 14,12,11,10,9,8 inject faults
// - warning bits 4,3,1,0 inject warnings
// - bits 13,6,5,2 stored, trigger nothing
// - lockout and output overvoltage fault fire while disabled
// - other injections act only while converting
// - single injection register, never saved
// - ident command returns fixed word
// - ident write acknowledged, then discarded
// - ident write flags no status error
module fcr_regs #(
   parameter int unsigned NVM_BYTES  = 32,
   parameter logic [15:0] IDENT_WORD = 16'hA5A5 // arbitrary value
) (
   // clock and reset
   input  wire logic                   ref_clk_in,
   input  wire logic                   rst_n_in,
   // command port from the management link
   input  wire logic [7:0]             cmd_code_in,
   input  wire logic                   cmd_wr_in,
   input  wire logic                   cmd_rd_in,
   input  wire logic [15:0]            cmd_wdata_in,
   output logic      [15:0]            cmd_rdata_out,
   output logic                        cmd_ack_out,
   output logic                        cmd_err_out,
   // settings image and its store events
   input  wire logic [NVM_BYTES*8-1:0] nvm_image_in,
   input  wire logic                   nvm_store_done_in,
   input  wire logic                   nvm_restore_done_in,
   output logic                        crc_busy_out,
   // power stage state and protection responses
   input  wire logic                   conv_en_in,
   input  wire logic                   fault_resp_done_in,
   input  wire logic                   warn_resp_done_in,
   // forced detector outputs
   output logic                        inject_overtemp_fault_out,
   output logic                        inject_overcurrent_fault_out,
   output logic                        inject_input_lockout_out,
   output logic                        inject_input_overvoltage_fault_out,
   output logic                        inject_output_undervoltage_fault_out,
   output logic                        inject_output_overvoltage_fault_out,
   output logic                        inject_overcurrent_warning_out,
   output logic                        inject_input_undervoltage_warning_out,
   output logic                        inject_output_undervoltage_warning_out,
   output logic                        inject_output_overvoltage_warning_out
);
   localparam int unsigned IDX_W = (NVM_BYTES > 1) ? $clog2(NVM_BYTES) : 1;
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(NVM_BYTES - 1);
   localparam int CRC_LAT = NVM_BYTES + 3;

   fcr_crc_if crc_if ();

   fcr_pkg::fcr_crc_state_t state_r;
   logic [IDX_W-1:0] idx_r;
   logic             pend_r;
   logic [15:0]      crc_r;
   logic [15:0]      inj_r;
   logic [15:0]      inj_clr;
   logic [15:0]      gate_mask;
   logic [15:0]      force_r;
   logic [15:0]      rdata_r;
   logic             ack_r;
   logic             err_r;
   logic             crc_start;
   logic             inj_wr;
   logic             crc_wr;

   // command codes answered by this block
   function automatic logic is_mapped(input logic [7:0] code);
      return (code == fcr_pkg::CMD_CRC) || (code == fcr_pkg::CMD_INJ) ||
             (code == fcr_pkg::CMD_IDENT);
   endfunction

   // crc engine fed one settings byte per cycle
   fcr_crc16 u_crc (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .crc_if     (crc_if)
   );


   // checksum sequencer

   assign crc_start = (state_r == fcr_pkg::ST_IDLE) && pend_r;

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         pend_r <= 1'b1; // boot run follows reset release
      end else if (nvm_store_done_in || nvm_restore_done_in) begin
         pend_r <= 1'b1; // a new request wins over the start
      end else if (crc_start) begin
         pend_r <= 1'b0;
      end
   end

   // sequencer state: idle, feed bytes, wait result
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         state_r <= fcr_pkg::ST_IDLE;
      end else begin
         case (state_r)
            fcr_pkg::ST_IDLE: begin
               if (pend_r) begin
                  state_r <= fcr_pkg::ST_FEED;
               end
            end
            fcr_pkg::ST_FEED: begin
               if (idx_r == IDX_LAST) begin
                  state_r <= fcr_pkg::ST_WAIT;
               end
            end
            fcr_pkg::ST_WAIT: begin
               if (crc_if.done) begin
                  state_r <= fcr_pkg::ST_IDLE;
               end
            end
            default: begin
               state_r <= fcr_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // byte index into the settings image
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         idx_r <= '0;
      end else if (state_r == fcr_pkg::ST_FEED) begin
         idx_r <= idx_r + IDX_W'(1);
      end else begin
         idx_r <= '0;
      end
   end

   assign crc_if.start = crc_start;
   assign crc_if.valid = (state_r == fcr_pkg::ST_FEED);
   assign crc_if.last  = (idx_r == IDX_LAST);
   assign crc_if.data  = nvm_image_in[idx_r*8 +: 8];

   // checksum held read-only, updated only by the engine
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         crc_r <= fcr_pkg::CRC_RESET;
      end else if (crc_if.done) begin
         crc_r <= crc_if.crc;
      end
   end

   assign crc_busy_out = pend_r || (state_r != fcr_pkg::ST_IDLE);


   // fault injection register, volatile, a single copy

   assign inj_wr = cmd_wr_in && (cmd_code_in == fcr_pkg::CMD_INJ);

   // fault group withdrawn after one response
   // warning group withdrawn after one response
   always_comb begin
      inj_clr = 16'h0000;
      if (fault_resp_done_in && !inj_r[fcr_pkg::FAULT_HOLD_BIT]) begin
         inj_clr = inj_clr | fcr_pkg::FAULT_MASK;
      end
      if (warn_resp_done_in && !inj_r[fcr_pkg::WARN_HOLD_BIT]) begin
         inj_clr = inj_clr | fcr_pkg::WARN_MASK;
      end
   end

   // reset to zero, no path to stored settings
   // auto-clear visible in readback; write wins
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         inj_r <= fcr_pkg::INJ_RESET;
      end else if (inj_wr) begin
         inj_r <= cmd_wdata_in;
      end else begin
         inj_r <= inj_r & ~inj_clr;
      end
   end

   // lockout and output overvoltage fault always pass
   assign gate_mask = conv_en_in ?
                      (fcr_pkg::FAULT_MASK | fcr_pkg::WARN_MASK) :
                      fcr_pkg::ALWAYS_MASK;

   // reserved and hold bits masked from the force
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         force_r <= 16'h0000;
      end else begin
         force_r <= inj_r & gate_mask;
      end
   end

   // forced bits drive the detector outputs
   assign inject_overtemp_fault_out   = force_r[fcr_pkg::OT_FAULT_BIT];
   assign inject_overcurrent_fault_out = force_r[fcr_pkg::OC_FAULT_BIT];
   assign inject_input_lockout_out    = force_r[fcr_pkg::LOCKOUT_BIT];
   assign inject_input_overvoltage_fault_out =
      force_r[fcr_pkg::VIN_OV_BIT];
   assign inject_output_undervoltage_fault_out =
      force_r[fcr_pkg::UV_FAULT_BIT];
   assign inject_output_overvoltage_fault_out =
      force_r[fcr_pkg::OV_FAULT_BIT];
   assign inject_overcurrent_warning_out = force_r[fcr_pkg::OC_WARN_BIT];
   assign inject_input_undervoltage_warning_out =
      force_r[fcr_pkg::VIN_UV_WARN_BIT];
   assign inject_output_undervoltage_warning_out =
      force_r[fcr_pkg::UV_WARN_BIT];
   assign inject_output_overvoltage_warning_out =
      force_r[fcr_pkg::OV_WARN_BIT];


   // command answers

   assign crc_wr = cmd_wr_in && (cmd_code_in == fcr_pkg::CMD_CRC);

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         rdata_r <= 16'h0000;
      end else if (cmd_rd_in) begin
         case (cmd_code_in)
            fcr_pkg::CMD_CRC:   rdata_r <= crc_r;
            fcr_pkg::CMD_INJ:   rdata_r <= inj_r;
            fcr_pkg::CMD_IDENT: rdata_r <= IDENT_WORD;
            default:            rdata_r <= 16'h0000;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (cmd_rd_in || cmd_wr_in) && is_mapped(cmd_code_in) &&
                  !crc_wr;
      end
   end

   // only a checksum write is an error
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         err_r <= 1'b0;
      end else begin
         err_r <= crc_wr;
      end
   end

   assign cmd_rdata_out = rdata_r;
   assign cmd_ack_out   = ack_r;
   assign cmd_err_out   = err_r;


   // checks

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_inj_write;
      cmd_wr_in && (cmd_code_in == fcr_pkg::CMD_INJ);
   endsequence

   sequence s_fault_release;
      fault_resp_done_in && !inj_r[fcr_pkg::FAULT_HOLD_BIT] && !inj_wr;
   endsequence

   sequence s_warn_release;
      warn_resp_done_in && !inj_r[fcr_pkg::WARN_HOLD_BIT] && !inj_wr;
   endsequence

   // a run finishes within the byte count plus three cycles
   a_crc_run_bound: assert property (
      crc_start |-> ##[1:CRC_LAT] crc_if.done)
      else $error("checksum run did not finish in time");

   // result lands in the checksum register
   a_crc_result_load: assert property (
      crc_if.done |=> crc_r == $past(crc_if.crc))
      else $error("checksum register missed engine result");

   // store request starts a fresh run
   a_store_restarts: assert property (
      (nvm_store_done_in || nvm_restore_done_in) |=>
      pend_r || (state_r != fcr_pkg::ST_IDLE))
      else $error("store event did not request checksum");

   a_inj_readback: assert property (
      s_inj_write ##1 (!inj_wr && !fault_resp_done_in &&
                       !warn_resp_done_in)
      ##1 (cmd_rd_in && cmd_code_in == fcr_pkg::CMD_INJ &&
           !inj_wr && !fault_resp_done_in && !warn_resp_done_in)
      |=> cmd_rdata_out == $past(cmd_wdata_in, 3))
      else $error("injection word not read back");

   // fault group cleared after one response
   a_fault_release: assert property (
      s_fault_release |=> (inj_r & fcr_pkg::FAULT_MASK) == 16'h0000)
      else $error("fault injection not withdrawn");

   a_fault_hold: assert property (
      (fault_resp_done_in && inj_r[fcr_pkg::FAULT_HOLD_BIT] &&
       !warn_resp_done_in && !inj_wr) |=> $stable(inj_r))
      else $error("held fault injection changed");

   // warning group cleared after one response
   a_warn_release: assert property (
      s_warn_release |=> (inj_r & fcr_pkg::WARN_MASK) == 16'h0000)
      else $error("warning injection not withdrawn");

   // while disabled only two outputs can force
   a_disabled_gate: assert property (
      !conv_en_in |=> (force_r & ~fcr_pkg::ALWAYS_MASK) == 16'h0000)
      else $error("injection forced while conversion disabled");

   // outputs follow the register when converting
   a_force_follow: assert property (
      conv_en_in |=> force_r ==
      ($past(inj_r) & (fcr_pkg::FAULT_MASK | fcr_pkg::WARN_MASK)))
      else $error("forced outputs do not follow injection");

   a_ident_fixed: assert property (
      (cmd_rd_in && cmd_code_in == fcr_pkg::CMD_IDENT) |=>
      cmd_rdata_out == IDENT_WORD)
      else $error("ident word read wrong value");

   a_ident_write_quiet: assert property (
      (cmd_wr_in && cmd_code_in == fcr_pkg::CMD_IDENT) |=>
      cmd_ack_out && !cmd_err_out)
      else $error("ident write flagged or not acked");
endmodule

// ### fcr_pkg.sv
// constants and types shared by the checksum and injection registers
package fcr_pkg;
   // command codes of the three registers
   localparam logic [7:0]  CMD_CRC         = 8'hF0;
   localparam logic [7:0]  CMD_INJ         = 8'hF1;
   localparam logic [7:0]  CMD_IDENT       = 8'hFC;
   // injection register field positions
   localparam int          FAULT_HOLD_BIT  = 15;
   localparam int          OT_FAULT_BIT    = 14;
   localparam int          OC_FAULT_BIT    = 12;
   localparam int          LOCKOUT_BIT     = 11;
   localparam int          VIN_OV_BIT      = 10;
   localparam int          UV_FAULT_BIT    = 9;
   localparam int          OV_FAULT_BIT    = 8;
   localparam int          WARN_HOLD_BIT   = 7;
   localparam int          OC_WARN_BIT     = 4;
   localparam int          VIN_UV_WARN_BIT = 3;
   localparam int          UV_WARN_BIT     = 1;
   localparam int          OV_WARN_BIT     = 0;
   // groups: bits 14,12..8 / bits 4,3,1,0 / bits 11,8
   localparam logic [15:0] FAULT_MASK      = 16'h5F00;
   localparam logic [15:0] WARN_MASK       = 16'h001B;
   localparam logic [15:0] ALWAYS_MASK     = 16'h0900;
   // reset values
   localparam logic [15:0] INJ_RESET       = 16'h0000;
   localparam logic [15:0] CRC_RESET       = 16'h0000;
   // checksum generator
   localparam logic [15:0] CRC_POLY        = 16'h8005;
   localparam logic [15:0] CRC_INIT        = 16'h0000;
   // checksum sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_FEED = 3'b010,
      ST_WAIT = 3'b100
   } fcr_crc_state_t;
endpackage

// ### fcr_crc_if.sv
// byte stream between checksum sequencer and crc engine
`timescale 1ns/10ps
interface fcr_crc_if;
   logic        start;
   logic        valid;
   logic        last;
   logic [7:0]  data;
   logic        done;
   logic [15:0] crc;
   // sequencer side
   modport feeder (output start, valid, last, data, input done, crc);
   // engine side
   modport engine (input start, valid, last, data, output done, crc);
endinterface

// ### fcr_crc16.sv
// byte-wide crc-16 engine, msb first, no reflection
`timescale 1ns/10ps
module fcr_crc16 (
   // clock and reset
   input  wire logic ref_clk_in,
   input  wire logic rst_n_in,
   // byte stream
   fcr_crc_if.engine crc_if
);
   logic [15:0] acc_r;
   logic        done_r;

   // one byte through the generator, bit by bit
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0]  d);
      logic [15:0] r;
      r = c ^ {d, 8'h00};
      for (int i = 0; i < 8; i++) begin
         if (r[15]) begin
            r = (r << 1) ^ fcr_pkg::CRC_POLY;
         end else begin
            r = r << 1;
         end
      end
      return r;
   endfunction

   // accumulator: start seeds, each valid byte folds in
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         acc_r <= fcr_pkg::CRC_INIT;
      end else if (crc_if.start) begin
         acc_r <= fcr_pkg::CRC_INIT;
      end else if (crc_if.valid) begin
         acc_r <= crc_step(acc_r, crc_if.data);
      end
   end

   // done pulses with the result of the last byte
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         done_r <= 1'b0;
      end else begin
         done_r <= crc_if.valid && crc_if.last && !crc_if.start;
      end
   end

   assign crc_if.crc  = acc_r;
   assign crc_if.done = done_r;
endmodule

// ### fcr_host.sv
// word access host model for the command port
`timescale 1ns/10ps
module fcr_host (
   // clock
   input  wire logic        ref_clk_in,
   // answers from the device
   input  wire logic [15:0] rdata_in,
   input  wire logic        ack_in,
   input  wire logic        err_in,
   // command strobes
   output logic      [7:0]  code_out,
   output logic             wr_out,
   output logic             rd_out,
   output logic      [15:0] wdata_out
);
   // idle lines before the first access
   initial begin
      code_out  = 8'h00;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      wdata_out = 16'h0000;
   end
   // one word access, answer taken just after the edge that samples it
   task automatic xfer(input logic wr, input logic [7:0] code,
                       input logic [15:0] wd, output logic [15:0] rd,
                       output logic ak, output logic er);
      @(posedge ref_clk_in) #1;
      code_out  = code;
      wdata_out = wd;
      wr_out    = wr;
      rd_out    = ~wr;
      @(posedge ref_clk_in) #1;
      // ack and err stand for this one cycle only
      rd = rdata_in;
      ak = ack_in;
      er = err_in;
      wr_out    = 1'b0;
      rd_out    = 1'b0;
      // released lines must not keep looking valid
      code_out  = ~code;
      wdata_out = ~wd;
   endtask
endmodule

// ### tb_fcr_regs.sv
// self-checking bench for the checksum, injection and ident registers
`timescale 1ns/10ps
module tb_fcr_regs;
   localparam int          NB    = 4;
   localparam logic [15:0] IDENT = 16'h3C96; // arbitrary value
   logic              ref_clk_in = 1'b0;
   logic              rst_n_in   = 1'b0;
   logic [7:0]        code;
   logic              wr;
   logic              rd;
   logic [15:0]       wdata;
   logic [15:0]       rdata;
   logic              ack;
   logic              err;
   logic [NB*8-1:0]   img        = 32'hC0DE0A5F;
   logic              store      = 1'b0;
   logic              restore    = 1'b0;
   logic              busy;
   logic              conv_en    = 1'b1;
   logic              fresp      = 1'b0;
   logic              wresp      = 1'b0;
   logic [9:0]        outs;
   logic [15:0]       rdv;
   logic              akv;
   logic              erv;
   logic [15:0]       old;
   int                n_errors   = 0;
   int                checks     = 0;
   int                cycles     = 0;

   // 10 MHz clock
   always #50 ref_clk_in = ~ref_clk_in;

   fcr_regs #(.NVM_BYTES(NB), .IDENT_WORD(IDENT)) dut_u (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .cmd_code_in(code), .cmd_wr_in(wr), .cmd_rd_in(rd),
      .cmd_wdata_in(wdata), .cmd_rdata_out(rdata),
      .cmd_ack_out(ack), .cmd_err_out(err),
      .nvm_image_in(img), .nvm_store_done_in(store),
      .nvm_restore_done_in(restore), .crc_busy_out(busy),
      .conv_en_in(conv_en), .fault_resp_done_in(fresp),
      .warn_resp_done_in(wresp),
      .inject_overtemp_fault_out(outs[9]),
      .inject_overcurrent_fault_out(outs[8]),
      .inject_input_lockout_out(outs[7]),
      .inject_input_overvoltage_fault_out(outs[6]),
      .inject_output_undervoltage_fault_out(outs[5]),
      .inject_output_overvoltage_fault_out(outs[4]),
      .inject_overcurrent_warning_out(outs[3]),
      .inject_input_undervoltage_warning_out(outs[2]),
      .inject_output_undervoltage_warning_out(outs[1]),
      .inject_output_overvoltage_warning_out(outs[0]));

   fcr_host host_u (
      .ref_clk_in(ref_clk_in), .rdata_in(rdata), .ack_in(ack),
      .err_in(err), .code_out(code), .wr_out(wr), .rd_out(rd),
      .wdata_out(wdata));

   // compare and count
   task automatic chk(input string what, input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask

   // verdict and end of run
   task automatic test_done();
      if (n_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // cut a hang short
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         test_done();
      end
   end

   // msb-first crc over the image, byte 0 first
   function automatic logic [15:0] crc16(input logic [NB*8-1:0] im);
      logic [15:0] c;
      logic        fb;
      c = 16'h0000;
      for (int k = 0; k < NB; k++) begin
         for (int b = 7; b >= 0; b--) begin
            fb = c[15] ^ im[8*k+b];
            c  = {c[14:0], 1'b0};
            if (fb) c = c ^ 16'h8005;
         end
      end
      return c;
   endfunction

   // forced outputs expected from a register value and enable
   function automatic logic [9:0] exp_outs(input logic [15:0] r,
                                           input logic en);
      return {r[14], r[12], r[11], r[10], r[9], r[8], r[4], r[3],
              r[1], r[0]} & (en ? 10'h3FF : 10'h090);
   endfunction

   task automatic acc(input logic w, input logic [7:0] c,
                      input logic [15:0] v);
      host_u.xfer(w, c, v, rdv, akv, erv);
   endtask

   task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
      acc(1'b0, c, 16'h0000);
      chk("read data", rdv, exp);
      chk("read answer", {14'h0000, akv, erv}, 16'h0002);
   endtask

   task automatic wr_chk(input logic [7:0] c, input logic [15:0] v,
                         input logic [15:0] ans);
      acc(1'b1, c, v);
      chk("write answer", {14'h0000, akv, erv}, ans);
   endtask

   task automatic out_chk(input logic [15:0] r, input logic en);
      repeat (2) @(posedge ref_clk_in);
      #1 chk("inject outs", {6'h00, outs}, {6'h00, exp_outs(r, en)});
   endtask

   task automatic pulse(ref logic s);
      @(posedge ref_clk_in) #1 s = 1'b1;
      @(posedge ref_clk_in) #1 s = 1'b0;
   endtask

   task automatic wait_crc();
      for (int i = 0; i < 100 && busy !== 1'b0; i++) begin
         @(posedge ref_clk_in) #1;
      end
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge ref_clk_in);
      #1 rst_n_in = 1'b1;
      chk("boot busy", {15'h0000, busy}, 16'h0001);
      chk("reset outs", {6'h00, outs}, 16'h0000);
      wait_crc();
      rd_chk(fcr_pkg::CMD_CRC, crc16(img));
      wr_chk(fcr_pkg::CMD_CRC, 16'hFFFF, 16'h0001);
      rd_chk(fcr_pkg::CMD_CRC, crc16(img));
      // store then restore, each with a new image
      for (int e = 0; e < 2; e++) begin
         old = crc16(img);
         img = e ? 32'hFFFFFFFF : 32'h80017E42;
         if (e) pulse(restore);
         else pulse(store);
         rd_chk(fcr_pkg::CMD_CRC, old);
         wait_crc();
         rd_chk(fcr_pkg::CMD_CRC, crc16(img));
      end
      // ident word, write taken but dropped
      rd_chk(fcr_pkg::CMD_IDENT, IDENT);
      wr_chk(fcr_pkg::CMD_IDENT, ~IDENT, 16'h0002);
      rd_chk(fcr_pkg::CMD_IDENT, IDENT);
      acc(1'b0, 8'hF2, 16'h0000);
      chk("unmapped", {rdv[13:0], akv, erv}, 16'h0000);
      // everything held, responses must not remove it
      wr_chk(fcr_pkg::CMD_INJ, 16'hFFFF, 16'h0002);
      rd_chk(fcr_pkg::CMD_INJ, 16'hFFFF);
      out_chk(16'hFFFF, 1'b1);
      pulse(fresp);
      pulse(wresp);
      out_chk(16'hFFFF, 1'b1);
      rd_chk(fcr_pkg::CMD_INJ, 16'hFFFF);
      conv_en = 1'b0;
      out_chk(16'hFFFF, 1'b0);
      conv_en = 1'b1;
      out_chk(16'hFFFF, 1'b1);
      // each bit alone, with conversion on and off
      for (int k = 0; k < 32; k++) begin
         conv_en = k[4];
         wr_chk(fcr_pkg::CMD_INJ, 16'h0001 << k[3:0], 16'h0002);
         out_chk(16'h0001 << k[3:0], k[4]);
      end
      // no hold: one response withdraws its group only
      wr_chk(fcr_pkg::CMD_INJ, 16'h7F7F, 16'h0002);
      out_chk(16'h7F7F, 1'b1);
      pulse(fresp);
      out_chk(16'h207F, 1'b1);
      rd_chk(fcr_pkg::CMD_INJ, 16'h207F);
      pulse(wresp);
      out_chk(16'h2064, 1'b1);
      rd_chk(fcr_pkg::CMD_INJ, 16'h2064);
      test_done();
   end
endmodule
